// file: hdl/slt_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  stairway light timer. Assumes inclusion by the package, the core and the bench.
*/
// Function
// - stairway: trigger rising edge turns lamp on
// - stairway: trigger falling edge restarts elapsed count
// - lamp turns off when count reaches delay
// - stairway: optional warning gap before expiry
// - stairway: new trigger restarts running delay
// - without retention, power loss clears lamp, count
// - with retention, power loss keeps lamp, count
// - each time from constant or selected block
// - multifunction: trigger rising edge turns lamp on
// - long press from off latches permanent light
// - short press starts the off-delay
// - multifunction: optional warning gap before expiry
// - later trigger while on turns lamp off
// - multifunction: clear zeroes count and turns lamp off
// - elapsed count is visible for readback
`ifndef SLT_REGS_SVH
`define SLT_REGS_SVH

`define SLT_ADDR_W 4
`define SLT_DATA_W 16
`define SLT_NUM_BLK 8

// ------------------------------------------------------------
// register offsets (word index)
// ------------------------------------------------------------
`define SLT_OFS_CTRL 4'h0
`define SLT_OFS_OFF_DELAY 4'h1
`define SLT_OFS_WARN_LEAD 4'h2
`define SLT_OFS_WARN_SPAN 4'h3
`define SLT_OFS_HOLD_SPAN 4'h4
`define SLT_OFS_SRC 4'h5
`define SLT_OFS_STATUS 4'h6
`define SLT_OFS_ELAPSED 4'h7

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SLT_CTRL_VARIANT 0
`define SLT_CTRL_WARN 1
`define SLT_CTRL_RETAIN 2
`define SLT_SRC_EXT 3
`define SLT_PAR_OFF 0
`define SLT_PAR_LEAD 1
`define SLT_PAR_SPAN 2
`define SLT_PAR_HOLD 3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SLT_RST_CTRL 3'h0
`define SLT_RST_OFF_DELAY 16'h00B4
`define SLT_RST_WARN_LEAD 16'h000F
`define SLT_RST_WARN_SPAN 16'h0001
`define SLT_RST_HOLD_SPAN 16'h0064
`define SLT_RST_SRC 16'h0000

// ------------------------------------------------------------
// timing: one timebase tick per period, clock at 50 MHz
// ------------------------------------------------------------
`define SLT_CLK_PERIOD_NS 20
`define SLT_TICK_PERIOD_NS 1000000
`define SLT_TICK_CYCLES (`SLT_TICK_PERIOD_NS / `SLT_CLK_PERIOD_NS)

`endif

// file: hdl/slt_pkg.sv
/*
  Types of the stairway light timer: modes, bus request, configuration and
  the whole state record. Assumes slt_regs.svh on the include path.
*/
`include "slt_regs.svh"

package slt_pkg;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_HOLD, S_DELAY, S_PERM} slt_mode_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [`SLT_ADDR_W-1:0] addr;
    logic [`SLT_DATA_W-1:0] wdata;
  } slt_bus_req_type;

  typedef struct packed {
    logic retain;
    logic warn_en;
    logic variant;
    logic [`SLT_DATA_W-1:0] off_delay;
    logic [`SLT_DATA_W-1:0] warn_lead;
    logic [`SLT_DATA_W-1:0] warn_span;
    logic [`SLT_DATA_W-1:0] hold_span;
    logic [`SLT_DATA_W-1:0] src;
  } slt_cfg_type;

  typedef struct packed {
    logic [1:0] trg_sync;
    logic trg_prev;
    logic [1:0] clr_sync;
    logic [15:0] prescale;
    slt_cfg_type cfg;
    slt_mode_type mode;
    logic on;
    logic [`SLT_DATA_W-1:0] elapsed_count;
    logic lamp_q;
    logic perm_q;
    logic [`SLT_DATA_W-1:0] rdata;
  } slt_state_type;

endpackage

// file: hdl/slt_core.sv
/*
  Stairway light timer core: stairway and multifunction variants sharing one
  elapsed counter, register port, parameter source select.
  Assumes pushbutton inputs are asynchronous, power loss input and register
  port come from logic on i_clk_sys.
*/
`timescale 1ns/1ps
`include "slt_regs.svh"

module slt_core
  import slt_pkg::*;
#(
  parameter int TICK_CYCLES = `SLT_TICK_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_trg,
  input wire logic i_clr,
  input wire logic i_pwr_loss,
  input wire logic [`SLT_NUM_BLK-1:0][`SLT_DATA_W-1:0] i_blk_val,
  input wire slt_bus_req_type i_bus,
  output logic [`SLT_DATA_W-1:0] o_rdata,
  output logic o_lamp,
  output logic o_permanent,
  output logic [`SLT_DATA_W-1:0] o_elapsed
);

  // ------------------------------------------------------------
  // state and combinational helpers
  // ------------------------------------------------------------
  slt_state_type st;
  slt_state_type next_st;
  logic tick;
  logic rise;
  logic fall;
  logic clr_on;
  logic warn_now;
  logic [16:0] cnt_inc;
  logic [16:0] warn_start;
  logic [16:0] warn_end;
  logic [3:0][`SLT_DATA_W-1:0] par_const;
  logic [3:0][`SLT_DATA_W-1:0] eff;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  // edges from the second sync stage only, against its own delayed copy
  assign rise = st.trg_sync[1] & ~st.trg_prev;
  assign fall = ~st.trg_sync[1] & st.trg_prev;
  assign clr_on = st.clr_sync[1];
  assign tick = (st.prescale == TICK_LAST);
  assign cnt_inc = {1'b0, st.elapsed_count} + 17'h00001;

  // each time value: stored constant or live value of a chosen block
  assign par_const[`SLT_PAR_OFF] = st.cfg.off_delay;
  assign par_const[`SLT_PAR_LEAD] = st.cfg.warn_lead;
  assign par_const[`SLT_PAR_SPAN] = st.cfg.warn_span;
  assign par_const[`SLT_PAR_HOLD] = st.cfg.hold_span;
  for (genvar g = 0; g < 4; g++) begin : g_src
    assign eff[g] = st.cfg.src[4*g+`SLT_SRC_EXT] ? i_blk_val[st.cfg.src[4*g +: 3]] : par_const[g];
  end

  // warning window; all three spans counted in the same ticks
  assign warn_start = {1'b0, eff[`SLT_PAR_OFF]} - {1'b0, eff[`SLT_PAR_LEAD]};
  assign warn_end = warn_start + {1'b0, eff[`SLT_PAR_SPAN]};
  always_comb begin
    // lead longer than the delay would start the gap before the count, so no gap
    warn_now = st.cfg.warn_en && st.mode == S_DELAY && eff[`SLT_PAR_LEAD] != 16'h0000
      && eff[`SLT_PAR_LEAD] <= eff[`SLT_PAR_OFF]
      && {1'b0, st.elapsed_count} >= warn_start && {1'b0, st.elapsed_count} < warn_end;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.trg_sync = {st.trg_sync[0], i_trg};
    next_st.trg_prev = st.trg_sync[1];
    next_st.clr_sync = {st.clr_sync[0], i_clr};
    next_st.prescale = tick ? 16'h0000 : st.prescale + 16'h0001;

    // register writes; status and elapsed are read only
    if (i_bus.wr) begin
      case (i_bus.addr)
        `SLT_OFS_CTRL: begin
          next_st.cfg.variant = i_bus.wdata[`SLT_CTRL_VARIANT];
          next_st.cfg.warn_en = i_bus.wdata[`SLT_CTRL_WARN];
          next_st.cfg.retain = i_bus.wdata[`SLT_CTRL_RETAIN];
        end
        `SLT_OFS_OFF_DELAY: next_st.cfg.off_delay = i_bus.wdata;
        `SLT_OFS_WARN_LEAD: next_st.cfg.warn_lead = i_bus.wdata;
        `SLT_OFS_WARN_SPAN: next_st.cfg.warn_span = i_bus.wdata;
        `SLT_OFS_HOLD_SPAN: next_st.cfg.hold_span = i_bus.wdata;
        `SLT_OFS_SRC: next_st.cfg.src = i_bus.wdata;
        default: ;
      endcase
    end

    // read data stand in the cycle after the strobe only
    next_st.rdata = 16'h0000;
    if (i_bus.rd) begin
      case (i_bus.addr)
        `SLT_OFS_CTRL: next_st.rdata = {13'h0000, st.cfg.retain, st.cfg.warn_en, st.cfg.variant};
        `SLT_OFS_OFF_DELAY: next_st.rdata = st.cfg.off_delay;
        `SLT_OFS_WARN_LEAD: next_st.rdata = st.cfg.warn_lead;
        `SLT_OFS_WARN_SPAN: next_st.rdata = st.cfg.warn_span;
        `SLT_OFS_HOLD_SPAN: next_st.rdata = st.cfg.hold_span;
        `SLT_OFS_SRC: next_st.rdata = st.cfg.src;
        `SLT_OFS_STATUS: next_st.rdata = {12'h000, warn_now, st.mode, st.on};
        `SLT_OFS_ELAPSED: next_st.rdata = st.elapsed_count;
        default: next_st.rdata = 16'h0000;
      endcase
    end

    // lamp sequence; power loss freezes or clears lamp, count and mode
    if (i_pwr_loss) begin
      if (!st.cfg.retain) begin
        next_st.on = 1'b0;
        next_st.elapsed_count = 16'h0000;
        next_st.mode = S_IDLE;
      end
      // retention: lamp, count and mode simply hold
    end else if (st.cfg.variant && clr_on) begin
      next_st.on = 1'b0;
      next_st.elapsed_count = 16'h0000;
      next_st.mode = S_IDLE;
    end else begin
      unique case (st.mode)
        S_IDLE: begin
          if (rise) begin
            next_st.on = 1'b1;
            next_st.elapsed_count = 16'h0000;
            next_st.mode = S_HOLD;
          end
        end
        S_HOLD: begin
          if (fall) begin
            next_st.elapsed_count = 16'h0000;
            next_st.mode = S_DELAY;
          end else if (st.cfg.variant && tick) begin
            if (cnt_inc >= {1'b0, eff[`SLT_PAR_HOLD]}) begin
              next_st.elapsed_count = 16'h0000;
              next_st.mode = S_PERM;
            end else begin
              next_st.elapsed_count = cnt_inc[15:0];
            end
          end
        end
        S_DELAY: begin
          if (rise && !st.cfg.variant) begin
            next_st.elapsed_count = 16'h0000;
            next_st.mode = S_HOLD;
          end else if (rise) begin
            next_st.on = 1'b0;
            next_st.elapsed_count = 16'h0000;
            next_st.mode = S_IDLE;
          end else if (tick) begin
            if (cnt_inc >= {1'b0, eff[`SLT_PAR_OFF]}) begin
              next_st.on = 1'b0;
              next_st.elapsed_count = 16'h0000;
              next_st.mode = S_IDLE;
            end else begin
              next_st.elapsed_count = cnt_inc[15:0];
            end
          end
        end
        S_PERM: begin
          if (rise) begin
            next_st.on = 1'b0;
            next_st.mode = S_IDLE;
          end
        end
      endcase
    end

    // lamp drops during the warning gap, then comes back until expiry
    next_st.lamp_q = st.on & ~warn_now;
    next_st.perm_q = (st.mode == S_PERM);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.mode <= S_IDLE;
      st.cfg.variant <= 1'(`SLT_RST_CTRL >> `SLT_CTRL_VARIANT);
      st.cfg.warn_en <= 1'(`SLT_RST_CTRL >> `SLT_CTRL_WARN);
      st.cfg.retain <= 1'(`SLT_RST_CTRL >> `SLT_CTRL_RETAIN);
      st.cfg.off_delay <= `SLT_RST_OFF_DELAY;
      st.cfg.warn_lead <= `SLT_RST_WARN_LEAD;
      st.cfg.warn_span <= `SLT_RST_WARN_SPAN;
      st.cfg.hold_span <= `SLT_RST_HOLD_SPAN;
      st.cfg.src <= `SLT_RST_SRC;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_lamp = st.lamp_q;
  assign o_permanent = st.perm_q;
  assign o_elapsed = st.elapsed_count;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_rise_on;
    rise && st.mode == S_IDLE && !i_pwr_loss && !(st.cfg.variant && clr_on) |-> ##1 st.on ##1 o_lamp;
  endproperty
  a_rise_on: assert property (p_rise_on) else $error("lamp not on after trigger rise");

  property p_fall_restart;
    !st.cfg.variant && st.mode == S_HOLD && fall && !i_pwr_loss
      |=> st.mode == S_DELAY && st.elapsed_count == 16'h0000 && st.on;
  endproperty
  a_fall_restart: assert property (p_fall_restart) else $error("fall did not restart delay");

  property p_expire;
    st.mode == S_DELAY && tick && !rise && !i_pwr_loss && !(st.cfg.variant && clr_on)
      && cnt_inc >= {1'b0, eff[`SLT_PAR_OFF]} |=> !st.on ##1 !o_lamp;
  endproperty
  a_expire: assert property (p_expire) else $error("lamp still on after delay");

  property p_warn_gap;
    st.on && warn_now |=> !o_lamp;
  endproperty
  a_warn_gap: assert property (p_warn_gap) else $error("lamp lit inside warning gap");

  property p_lamp_follows;
    st.on && !warn_now |=> o_lamp;
  endproperty
  a_lamp_follows: assert property (p_lamp_follows) else $error("lamp dark outside warning gap");

  property p_retrigger;
    !st.cfg.variant && st.mode == S_DELAY && rise && !i_pwr_loss
      |=> st.mode == S_HOLD && st.elapsed_count == 16'h0000 && st.on;
  endproperty
  a_retrigger: assert property (p_retrigger) else $error("retrigger did not restart");

  property p_loss_clear;
    i_pwr_loss && !st.cfg.retain |=> !st.on && st.elapsed_count == 16'h0000 ##1 !o_lamp;
  endproperty
  a_loss_clear: assert property (p_loss_clear) else $error("power loss left lamp state");

  property p_loss_keep;
    i_pwr_loss && st.cfg.retain |=> $stable(st.on) && $stable(st.elapsed_count) && $stable(st.mode);
  endproperty
  a_loss_keep: assert property (p_loss_keep) else $error("retained state changed");

  property p_perm_enter;
    st.cfg.variant && st.mode == S_HOLD && tick && !fall && !clr_on && !i_pwr_loss
      && cnt_inc >= {1'b0, eff[`SLT_PAR_HOLD]} |=> st.mode == S_PERM && st.on ##1 o_permanent;
  endproperty
  a_perm_enter: assert property (p_perm_enter) else $error("long press not latched");

  property p_short_press;
    st.cfg.variant && st.mode == S_HOLD && fall && !clr_on && !i_pwr_loss
      |=> st.mode == S_DELAY && st.elapsed_count == 16'h0000;
  endproperty
  a_short_press: assert property (p_short_press) else $error("short press did not start delay");

  property p_toggle_off;
    st.cfg.variant && (st.mode == S_DELAY || st.mode == S_PERM) && rise && !clr_on && !i_pwr_loss
      |=> !st.on ##1 !o_lamp;
  endproperty
  a_toggle_off: assert property (p_toggle_off) else $error("later trigger left lamp on");

  property p_clear;
    st.cfg.variant && clr_on && !i_pwr_loss |=> !st.on && st.elapsed_count == 16'h0000 && st.mode == S_IDLE;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not win");

  property p_count_step;
    st.mode == S_DELAY && tick && !rise && !i_pwr_loss && !(st.cfg.variant && clr_on)
      && cnt_inc < {1'b0, eff[`SLT_PAR_OFF]} |=> st.elapsed_count == $past(st.elapsed_count) + 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step on tick");

  // permanent light only ends by a trigger, clear or power loss
  property p_perm_hold;
    st.mode == S_PERM && !rise && !i_pwr_loss && !(st.cfg.variant && clr_on)
      |=> st.mode == S_PERM && o_lamp;
  endproperty
  a_perm_hold: assert property (p_perm_hold) else $error("permanent light dropped");

  property p_readback;
    i_bus.rd && i_bus.addr == `SLT_OFS_ELAPSED |=> o_rdata == $past(st.elapsed_count);
  endproperty
  a_readback: assert property (p_readback) else $error("elapsed readback wrong");

  property p_rdata_idle;
    !i_bus.rd |=> o_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data stood too long");

  c_stair_expire: cover property (!st.cfg.variant && st.mode == S_DELAY && st.on ##1 !st.on);
  c_perm: cover property (st.mode == S_HOLD ##1 st.mode == S_PERM);
  c_warn: cover property (st.on && warn_now ##1 !warn_now && st.on);
  c_clear: cover property (st.cfg.variant && clr_on && st.on);
  c_retrig: cover property (!st.cfg.variant && st.mode == S_DELAY && rise);

endmodule

// file: verif/slt_button.sv
/*
  Pushbutton model on the trigger pin of the light timer.
  Assumes one bench process calls pin() at a time, just after a rising edge.
*/
`timescale 1ns/1ps
module slt_button (
  input wire logic i_clk_sys,
  output logic o_trg
);
  // ------------------------------------------------------------
  // button level
  // ------------------------------------------------------------
  // released between presses, as a real button
  initial o_trg = 1'b0;
  // under 3 edges the 2-flop sync may swallow the level, so floor it at 3
  task automatic pin(input logic v, input int n);
    @(posedge i_clk_sys);
    o_trg <= v;
    repeat ((n < 3) ? 3 : n) @(posedge i_clk_sys);
  endtask
endmodule

// file: verif/slt_core_tb_top.sv
/*
  Self-checking bench of the light timer core with a pushbutton model.
  Assumes slt_regs.svh on the include path; a 2-cycle tick keeps runs short.
*/
`timescale 1ns/1ps
`include "slt_regs.svh"
module slt_core_tb_top;
  import slt_pkg::*;
  localparam int TK = 2;
  logic i_clk_sys;
  logic i_rst;
  logic i_trg;
  logic i_clr;
  logic i_pwr_loss;
  logic [`SLT_NUM_BLK-1:0][`SLT_DATA_W-1:0] i_blk_val;
  slt_bus_req_type i_bus;
  logic [15:0] o_rdata;
  logic [15:0] o_elapsed;
  logic o_lamp;
  logic o_permanent;
  logic rd_pend;
  logic [15:0] exp_q[$];
  logic [15:0] lfsr;
  int err_count;
  int n_compared;
  int v;

  slt_button i_btn (.i_clk_sys(i_clk_sys), .o_trg(i_trg));
  slt_core #(.TICK_CYCLES(TK)) i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_trg(i_trg), .i_clr(i_clr),
    .i_pwr_loss(i_pwr_loss), .i_blk_val(i_blk_val), .i_bus(i_bus), .o_rdata(o_rdata), .o_lamp(o_lamp),
    .o_permanent(o_permanent), .o_elapsed(o_elapsed));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one strobe cycle, then an idle edge so no signal is driven twice at once
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    if (!w) begin
      exp_q.push_back(d);
    end
    @(posedge i_clk_sys);
    i_bus <= '{wr: w, rd: !w, addr: a, wdata: w ? d : 16'h0000};
    @(posedge i_clk_sys);
    i_bus <= '0;
  endtask

  // read data is only valid in the cycle after the strobe; look mid-cycle
  always @(negedge i_clk_sys) begin
    if (rd_pend) begin
      check("rdata", o_rdata, exp_q.pop_front());
    end
    rd_pend = i_bus.rd;
  end

  // watch the lamp from the release until it stays dark 12 cycles
  task automatic timed(input int lo, input int hi, input logic warn);
    int t;
    int rises;
    int gap;
    int low_run;
    t = 0;
    rises = 0;
    gap = 0;
    low_run = 0;
    for (int k = 0; k < 400 && low_run < 12; k++) begin
      @(negedge i_clk_sys);
      if (o_lamp !== 1'b1) begin
        low_run++;
      end else begin
        rises += (low_run > 0);
        gap = (low_run > 0) ? low_run : gap;
        low_run = 0;
        t = k + 1;
      end
    end
    if (low_run < 12) begin
      err_count++;
      finish_test();
    end
    check("expiry_ok", 16'((t >= lo) && (t <= hi)), 16'h0001);
    check("warn_rises", 16'(rises), {15'h0000, warn});
    check("warn_gap", 16'(gap), warn ? 16'h0004 : 16'h0000);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    i_rst = 1'b1;
    i_clr = 1'b0;
    i_pwr_loss = 1'b0;
    i_blk_val = '0;
    i_bus = '0;
    rd_pend = 1'b0;
    lfsr = 16'h0031;
    err_count = 0;
    n_compared = 0;
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    // defaults, a read-only place and an unmapped one
    bus(1'b0, `SLT_OFS_CTRL, 16'(`SLT_RST_CTRL));
    bus(1'b0, `SLT_OFS_OFF_DELAY, `SLT_RST_OFF_DELAY);
    bus(1'b0, `SLT_OFS_WARN_LEAD, `SLT_RST_WARN_LEAD);
    bus(1'b0, `SLT_OFS_WARN_SPAN, `SLT_RST_WARN_SPAN);
    bus(1'b0, `SLT_OFS_HOLD_SPAN, `SLT_RST_HOLD_SPAN);
    bus(1'b0, `SLT_OFS_SRC, `SLT_RST_SRC);
    bus(1'b1, `SLT_OFS_ELAPSED, 16'h1234);
    bus(1'b0, `SLT_OFS_ELAPSED, 16'h0000);
    bus(1'b1, 4'h9, 16'hFFFF);
    bus(1'b0, 4'h9, 16'h0000);
    // all times in ticks of one timebase
    bus(1'b1, `SLT_OFS_OFF_DELAY, 16'h000A);
    bus(1'b1, `SLT_OFS_WARN_LEAD, 16'h0004);
    bus(1'b1, `SLT_OFS_WARN_SPAN, 16'h0002);
    bus(1'b1, `SLT_OFS_HOLD_SPAN, 16'h0005);
    $display("test registers done");
    // both variants with and without warning
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, `SLT_OFS_CTRL, 16'(c));
      i_btn.pin(1'b1, 6);
      @(negedge i_clk_sys);
      check("lamp_on", 16'(o_lamp), 16'h0001);
      i_btn.pin(1'b0, 3);
      timed(18, 22, c[1]);
    end
    // stairway: count held until release, retrigger restarts
    bus(1'b1, `SLT_OFS_CTRL, 16'h0000);
    i_btn.pin(1'b1, 20);
    @(negedge i_clk_sys);
    check("hold_count", o_elapsed, 16'h0000);
    i_btn.pin(1'b0, 10);
    i_btn.pin(1'b1, 4);
    @(negedge i_clk_sys);
    check("retrig_lamp", 16'(o_lamp), 16'h0001);
    i_btn.pin(1'b0, 3);
    timed(18, 22, 1'b0);
    $display("test delay done");
    // multifunction: long press latches, next press and delay press turn off
    bus(1'b1, `SLT_OFS_CTRL, 16'h0001);
    i_btn.pin(1'b1, 8);
    @(negedge i_clk_sys);
    check("hold_elapsed", 16'((o_elapsed >= 1) && (o_elapsed <= 3)), 16'h0001);
    i_btn.pin(1'b1, 20);
    @(negedge i_clk_sys);
    check("perm", 16'(o_permanent), 16'h0001);
    bus(1'b0, `SLT_OFS_STATUS, 16'h0007);
    bus(1'b0, `SLT_OFS_ELAPSED, 16'h0000);
    i_btn.pin(1'b0, 6);
    @(negedge i_clk_sys);
    check("perm_lamp", 16'(o_lamp), 16'h0001);
    i_btn.pin(1'b1, 6);
    @(negedge i_clk_sys);
    check("perm_off", 16'({o_lamp, o_permanent}), 16'h0000);
    i_btn.pin(1'b0, 4);
    i_btn.pin(1'b1, 4);
    i_btn.pin(1'b0, 6);
    i_btn.pin(1'b1, 6);
    @(negedge i_clk_sys);
    check("delay_off", 16'(o_lamp), 16'h0000);
    i_btn.pin(1'b0, 4);
    // clear zeroes and beats a trigger
    i_btn.pin(1'b1, 4);
    i_btn.pin(1'b0, 6);
    @(posedge i_clk_sys);
    i_clr <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    check("clr_lamp", 16'(o_lamp), 16'h0000);
    check("clr_count", o_elapsed, 16'h0000);
    i_btn.pin(1'b1, 6);
    @(negedge i_clk_sys);
    check("clr_wins", 16'(o_lamp), 16'h0000);
    i_btn.pin(1'b0, 4);
    i_clr <= 1'b0;
    $display("test multifunction done");
    // power loss without and with retention
    i_btn.pin(1'b1, 4);
    i_btn.pin(1'b0, 6);
    @(posedge i_clk_sys);
    i_pwr_loss <= 1'b1;
    @(posedge i_clk_sys);
    i_pwr_loss <= 1'b0;
    // lamp register lags the cleared state by one more edge
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    check("loss_clear", 16'({o_lamp, o_elapsed[14:0]}), 16'h0000);
    bus(1'b1, `SLT_OFS_CTRL, 16'h0005);
    i_btn.pin(1'b1, 4);
    i_btn.pin(1'b0, 3);
    @(posedge i_clk_sys);
    i_pwr_loss <= 1'b1;
    repeat (9) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    check("loss_keep", 16'(o_lamp), 16'h0001);
    @(posedge i_clk_sys);
    i_pwr_loss <= 1'b0;
    timed(17, 22, 1'b0);
    // full reset clears even with retention
    i_btn.pin(1'b1, 6);
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(negedge i_clk_sys);
    check("rst_lamp", 16'(o_lamp), 16'h0000);
    bus(1'b0, `SLT_OFS_CTRL, 16'h0000);
    i_btn.pin(1'b0, 4);
    $display("test power done");
    // off-delay taken live from a random block value
    for (int b = 0; b < 8; b++) begin
      lfsr = lfsr_next(lfsr);
      i_blk_val[b] <= 16'h0004 + {13'h0000, lfsr[2:0]};
    end
    v = 4 + lfsr[2:0];
    bus(1'b1, `SLT_OFS_SRC, 16'h000F);
    bus(1'b0, `SLT_OFS_SRC, 16'h000F);
    i_btn.pin(1'b1, 6);
    i_btn.pin(1'b0, 3);
    timed(2 * v - 2, 2 * v + 2, 1'b0);
    $display("test source done");
    finish_test();
  end
endmodule
